// *** core/hvcr_pkg.sv ***
// Constants shared by the hypervisor configuration register bank.
// Assumes the core presents system-register accesses already split into encoding fields.
package hvcr_pkg;

    // Encoding of this bank; prefix shared by all registers, opc2 per register
    localparam logic [3:0] ENC_COPROC       = 4'hF;
    localparam logic [2:0] ENC_OPC1         = 3'h4;
    localparam logic [3:0] ENC_CRN          = 4'h1;
    localparam logic [3:0] ENC_CRM          = 4'h1;
    localparam logic [2:0] ENC_OPC2_CFG     = 3'h0;
    localparam logic [2:0] ENC_OPC2_DEBUG   = 3'h1;
    localparam logic [2:0] ENC_OPC2_SECOND  = 3'h4;

    // Field positions of the first register
    localparam int POS_FORCE_BCAST   = 9;
    localparam int POS_VABORT_PEND   = 8;
    localparam int POS_VIRQ_PEND     = 7;
    localparam int POS_VFIQ_PEND     = 6;
    localparam int POS_ABORT_OVR     = 5;
    localparam int POS_IRQ_OVR       = 4;
    localparam int POS_FIQ_OVR       = 3;
    localparam int POS_SETWAY_OVR    = 1;
    localparam int POS_VIRT_EN       = 0;

    // Field position of the second register
    localparam int POS_MISMATCH_COH  = 6;

    // Reset values
    localparam logic [9:0]  RST_CFG_LOW      = 10'h000;
    localparam logic        RST_MISMATCH_COH = 1'b0;
    localparam logic [31:0] RST_DEBUG_CTRL   = 32'h0000_0000;

    // Execution levels
    typedef enum logic [1:0] {
        LVL_USER  = 2'h0,
        LVL_GUEST = 2'h1,
        LVL_HYP   = 2'h2
    } hvcr_level_t;

    // Cache and predictor maintenance operations
    typedef enum logic [2:0] {
        CMO_BP_INVAL_ALL      = 3'h0,
        CMO_IC_INVAL_ALL      = 3'h1,
        CMO_DC_INVAL_SETWAY   = 3'h2,
        CMO_DC_CLEAN_INV_SW   = 3'h3,
        CMO_DC_INVAL_ADDR     = 3'h4,
        CMO_DC_CLEAN_INV_ADDR = 3'h5,
        CMO_OTHER             = 3'h6
    } hvcr_cmo_t;

    // Register selected by an access
    typedef enum logic [1:0] {
        SEL_NONE   = 2'h0,
        SEL_CFG    = 2'h1,
        SEL_SECOND = 2'h2,
        SEL_DEBUG  = 2'h3
    } hvcr_sel_t;

endpackage

// *** core/hvcr_access_decode.sv ***
// Decoder for system-register accesses aimed at this bank, with the privilege check.
// Assumes all inputs are stable in the request cycle; purely combinational.
`timescale 1ns/10ps
module hvcr_access_decode (
    input  wire logic [3:0]          coproc_i,   // Coprocessor field
    input  wire logic [2:0]          opc1_i,     // Opc1 field
    input  wire logic [3:0]          crn_i,      // CRn field
    input  wire logic [3:0]          crm_i,      // CRm field
    input  wire logic [2:0]          opc2_i,     // Opc2 field
    input  wire hvcr_pkg::hvcr_level_t level_i,  // Level issuing the access
    input  wire logic                trap_t1_i,  // Hypervisor trap bit T1
    output hvcr_pkg::hvcr_sel_t      sel_o,      // Register addressed
    output logic                     allow_o,    // Access may proceed
    output logic                     trap_o,     // Trap to hypervisor mode
    output logic                     undef_o     // Undefined instruction
);

    logic base_hit;

    // Common encoding prefix of the bank
    assign base_hit = (coproc_i == hvcr_pkg::ENC_COPROC) && (opc1_i == hvcr_pkg::ENC_OPC1) &&
                      (crn_i == hvcr_pkg::ENC_CRN) && (crm_i == hvcr_pkg::ENC_CRM);

    // Register select from opc2
    always_comb begin
        sel_o = hvcr_pkg::SEL_NONE;
        if (base_hit) begin
            case (opc2_i)
                hvcr_pkg::ENC_OPC2_CFG:    sel_o = hvcr_pkg::SEL_CFG;
                hvcr_pkg::ENC_OPC2_SECOND: sel_o = hvcr_pkg::SEL_SECOND;
                hvcr_pkg::ENC_OPC2_DEBUG:  sel_o = hvcr_pkg::SEL_DEBUG;
                default:                   sel_o = hvcr_pkg::SEL_NONE;
            endcase
        end
    end

    // Privilege: hypervisor only; guest traps when T1 set, else undefined
    always_comb begin
        allow_o = 1'b0;
        trap_o  = 1'b0;
        undef_o = 1'b0;
        if (sel_o != hvcr_pkg::SEL_NONE) begin
            case (level_i)
                hvcr_pkg::LVL_HYP:   allow_o = 1'b1;
                hvcr_pkg::LVL_GUEST: begin
                    trap_o  = trap_t1_i;
                    undef_o = ~trap_t1_i;
                end
                default:             undef_o = 1'b1;
            endcase
        end
    end

endmodule

// *** core/hvcr_cmo_xlate.sv ***
// Rewrites cache and predictor maintenance operations under hypervisor control.
// Assumes one operation per valid cycle; purely combinational.
`timescale 1ns/10ps
module hvcr_cmo_xlate (
    input  wire hvcr_pkg::hvcr_cmo_t   op_i,          // Incoming operation
    input  wire hvcr_pkg::hvcr_level_t level_i,       // Level issuing it
    input  wire logic                  force_bcast_i, // Force-broadcast field
    input  wire logic                  setway_ovr_i,  // Effective set/way override
    input  wire logic                  virt_en_i,     // Effective virtualization enable
    output hvcr_pkg::hvcr_cmo_t        op_o,          // Operation to perform
    output logic                       bcast_o        // Broadcast to inner shareable
);

    logic guest;

    assign guest = (level_i == hvcr_pkg::LVL_GUEST);

    // Upgrade invalidates to clean-and-invalidate at guest level
    always_comb begin
        op_o = op_i;
        if (guest) begin
            case (op_i)
                hvcr_pkg::CMO_DC_INVAL_SETWAY: begin
                    if (setway_ovr_i || virt_en_i) begin
                        op_o = hvcr_pkg::CMO_DC_CLEAN_INV_SW;
                    end
                end
                hvcr_pkg::CMO_DC_INVAL_ADDR: begin
                    if (virt_en_i) begin
                        op_o = hvcr_pkg::CMO_DC_CLEAN_INV_ADDR;
                    end
                end
                default: op_o = op_i;
            endcase
        end
    end

    // Only the two invalidate-all operations are widened
    assign bcast_o = guest && force_bcast_i &&
                     ((op_i == hvcr_pkg::CMO_BP_INVAL_ALL) || (op_i == hvcr_pkg::CMO_IC_INVAL_ALL));

endmodule

// *** core/hvcr_regs.sv ***
// Hypervisor configuration register bank: first and second configuration registers,
// debug control storage, virtual exception signalling and maintenance rewriting.
// Assumes the core gives one access request per pulse and all inputs synchronous to CLK_I.
// Behaviour
// - Force-broadcast makes guest predictor and icache invalidate-all broadcast inner shareable.
// - Virtual abort pending bit delivered only while abort override effective.
// - Virtual IRQ pending bit delivered only while IRQ override effective.
// - Virtual FIQ pending bit delivered only while FIQ override effective.
// - Abort override ignores status abort mask and enables virtual abort.
// - IRQ override ignores status IRQ mask and enables virtual IRQ.
// - FIQ override ignores status FIQ mask and enables virtual FIQ.
// - Trap-general-exceptions forces abort, IRQ and FIQ overrides effective; reads return stored values.
// - Virtual exceptions look to the guest exactly like physical ones.
// - Set/way override turns guest set/way invalidate into clean-and-invalidate.
// - Set/way override may read as one; writable form resets to zero.
// - Virtualization enable turns on second-stage protection for guest and user.
// - Default cacheability acts as virtualization enable outside hypervisor mode.
// - Virtualization enable upgrades guest data-cache invalidates to clean-and-invalidate.
// - Bits nine down to zero of first register reset to zero.
// - Encoding coproc 1111, opc1 100, CRn/CRm 0001; opc2 selects register.
// - Hypervisor-only access; guest traps on T1; user never reaches them.
// - Coherency control for guest regime; may be built read-as-zero.
// - Second register reserved bits read zero; writable field reset unknown.
// - Debug control register is warm-domain, unknown after warm or cold reset.
`timescale 1ns/10ps
module hvcr_regs #(
    parameter bit SETWAY_READ_AS_ONE  = 1'b0,  // Build set/way override as read-as-one
    parameter bit MISMATCH_READ_ZERO  = 1'b0   // Build coherency control as read-as-zero
) (
    input  wire logic                  CLK_I,          // Core clock, 40 MHz
    input  wire logic                  RESET_N_I,      // Async reset, active low
    input  wire logic                  SYS_REQ_I,      // Access request pulse
    input  wire logic                  SYS_WRITE_I,    // 1 write, 0 read
    input  wire logic [3:0]            SYS_COPROC_I,   // Coprocessor field
    input  wire logic [2:0]            SYS_OPC1_I,     // Opc1 field
    input  wire logic [3:0]            SYS_CRN_I,      // CRn field
    input  wire logic [3:0]            SYS_CRM_I,      // CRm field
    input  wire logic [2:0]            SYS_OPC2_I,     // Opc2 field
    input  wire logic [31:0]           SYS_WDATA_I,    // Write data
    input  wire hvcr_pkg::hvcr_level_t CUR_LEVEL_I,    // Current execution level
    input  wire logic                  HYP_TRAP_T1_I,  // Hypervisor trap bit T1
    input  wire logic                  TRAP_GEN_EXC_I, // Trap-general-exceptions control
    input  wire logic                  DEFAULT_CACHE_I,// Default cacheability control
    input  wire logic                  STATUS_ABORT_MASK_I, // Current-status abort mask
    input  wire logic                  STATUS_IRQ_MASK_I,   // Current-status IRQ mask
    input  wire logic                  STATUS_FIQ_MASK_I,   // Current-status FIQ mask
    input  wire logic                  CMO_REQ_I,      // Maintenance op valid
    input  wire hvcr_pkg::hvcr_cmo_t   CMO_OP_I,       // Maintenance op
    output logic                       SYS_ACK_O,      // Access answered pulse
    output logic                       SYS_HIT_O,      // Encoding belongs to this bank
    output logic [31:0]                SYS_RDATA_O,    // Read data
    output logic                       SYS_TRAP_O,     // Trap to hypervisor mode
    output logic                       SYS_UNDEF_O,    // Undefined instruction
    output logic                       VIRT_ABORT_O,   // Virtual async abort level
    output logic                       VIRT_IRQ_O,     // Virtual IRQ level
    output logic                       VIRT_FIQ_O,     // Virtual FIQ level
    output logic                       ABORT_MASK_EFF_O, // Effective status abort mask
    output logic                       IRQ_MASK_EFF_O, // Effective status IRQ mask
    output logic                       FIQ_MASK_EFF_O, // Effective status FIQ mask
    output logic                       STAGE2_EN_O,    // Second-stage protection on
    output logic                       MISMATCH_COH_O, // Mismatch may lose coherency
    output logic                       CMO_REQ_O,      // Rewritten op valid
    output hvcr_pkg::hvcr_cmo_t        CMO_OP_O,       // Rewritten op
    output logic                       CMO_BCAST_O     // Broadcast to inner shareable
);

    // Stored fields of the first register
    logic        force_bcast_q;
    logic        vabort_pend_q;
    logic        virq_pend_q;
    logic        vfiq_pend_q;
    logic        abort_ovr_q;
    logic        irq_ovr_q;
    logic        fiq_ovr_q;
    logic        setway_ovr_q;
    logic        virt_en_q;
    // Second register and debug control storage
    logic        mismatch_coh_q;
    logic [31:0] debug_ctrl_q;

    // Decode results
    hvcr_pkg::hvcr_sel_t sel;
    logic                allow;
    logic                trap;
    logic                undef;
    logic                wr_en;
    logic                wr_cfg;
    logic                wr_second;
    logic                wr_debug;
    logic [31:0]         rdata_d;

    // Effective controls
    logic                abort_ovr_eff;
    logic                irq_ovr_eff;
    logic                fiq_ovr_eff;
    logic                setway_ovr_eff;
    logic                virt_en_eff;
    logic                setway_read;
    logic                mismatch_read;
    hvcr_pkg::hvcr_cmo_t cmo_op_d;
    logic                cmo_bcast_d;

    // Override as seen by everything except a direct read
    function automatic logic eff_override(input logic stored, input logic trap_general_exceptions);
        eff_override = stored | trap_general_exceptions;
    endfunction

    // Access decode and privilege check
    hvcr_access_decode u_decode (
        .coproc_i  (SYS_COPROC_I),
        .opc1_i    (SYS_OPC1_I),
        .crn_i     (SYS_CRN_I),
        .crm_i     (SYS_CRM_I),
        .opc2_i    (SYS_OPC2_I),
        .level_i   (CUR_LEVEL_I),
        .trap_t1_i (HYP_TRAP_T1_I),
        .sel_o     (sel),
        .allow_o   (allow),
        .trap_o    (trap),
        .undef_o   (undef)
    );

    // Writes land only when the access is allowed
    assign wr_en     = SYS_REQ_I && SYS_WRITE_I && allow;
    assign wr_cfg    = wr_en && (sel == hvcr_pkg::SEL_CFG);
    assign wr_second = wr_en && (sel == hvcr_pkg::SEL_SECOND);
    assign wr_debug  = wr_en && (sel == hvcr_pkg::SEL_DEBUG);

    // Effective overrides; stored values are untouched by the trap control
    assign abort_ovr_eff = eff_override(abort_ovr_q, TRAP_GEN_EXC_I);
    assign irq_ovr_eff   = eff_override(irq_ovr_q, TRAP_GEN_EXC_I);
    assign fiq_ovr_eff   = eff_override(fiq_ovr_q, TRAP_GEN_EXC_I);

    // Default cacheability stands in for the enable outside hypervisor mode
    assign virt_en_eff = virt_en_q |
                         (DEFAULT_CACHE_I && (CUR_LEVEL_I != hvcr_pkg::LVL_HYP));

    // Read-as-one build keeps the override permanently active
    assign setway_ovr_eff = SETWAY_READ_AS_ONE ? 1'b1 : setway_ovr_q;
    assign setway_read    = setway_ovr_eff;
    assign mismatch_read  = MISMATCH_READ_ZERO ? 1'b0 : mismatch_coh_q;

    // First-register fields; all reset to zero
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            force_bcast_q <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_FORCE_BCAST];
            vabort_pend_q <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_VABORT_PEND];
            virq_pend_q   <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_VIRQ_PEND];
            vfiq_pend_q   <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_VFIQ_PEND];
            abort_ovr_q   <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_ABORT_OVR];
            irq_ovr_q     <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_IRQ_OVR];
            fiq_ovr_q     <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_FIQ_OVR];
            setway_ovr_q  <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_SETWAY_OVR];
            virt_en_q     <= hvcr_pkg::RST_CFG_LOW[hvcr_pkg::POS_VIRT_EN];
        end else if (wr_cfg) begin
            force_bcast_q <= SYS_WDATA_I[hvcr_pkg::POS_FORCE_BCAST];
            vabort_pend_q <= SYS_WDATA_I[hvcr_pkg::POS_VABORT_PEND];
            virq_pend_q   <= SYS_WDATA_I[hvcr_pkg::POS_VIRQ_PEND];
            vfiq_pend_q   <= SYS_WDATA_I[hvcr_pkg::POS_VFIQ_PEND];
            abort_ovr_q   <= SYS_WDATA_I[hvcr_pkg::POS_ABORT_OVR];
            irq_ovr_q     <= SYS_WDATA_I[hvcr_pkg::POS_IRQ_OVR];
            fiq_ovr_q     <= SYS_WDATA_I[hvcr_pkg::POS_FIQ_OVR];
            setway_ovr_q  <= SYS_WDATA_I[hvcr_pkg::POS_SETWAY_OVR];
            virt_en_q     <= SYS_WDATA_I[hvcr_pkg::POS_VIRT_EN];
        end
    end

    // Second register: only the coherency bit is stored; reset value is a free pick
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mismatch_coh_q <= hvcr_pkg::RST_MISMATCH_COH;
        end else if (wr_second) begin
            mismatch_coh_q <= SYS_WDATA_I[hvcr_pkg::POS_MISMATCH_COH];
        end
    end

    // Debug control: plain storage, field meaning lives elsewhere in the core
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            debug_ctrl_q <= hvcr_pkg::RST_DEBUG_CTRL;
        end else if (wr_debug) begin
            debug_ctrl_q <= SYS_WDATA_I;
        end
    end

    // Read mux; direct reads show stored fields, not effective ones
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (allow && !SYS_WRITE_I) begin
            case (sel)
                hvcr_pkg::SEL_CFG: begin
                    rdata_d[hvcr_pkg::POS_FORCE_BCAST] = force_bcast_q;
                    rdata_d[hvcr_pkg::POS_VABORT_PEND] = vabort_pend_q;
                    rdata_d[hvcr_pkg::POS_VIRQ_PEND]   = virq_pend_q;
                    rdata_d[hvcr_pkg::POS_VFIQ_PEND]   = vfiq_pend_q;
                    rdata_d[hvcr_pkg::POS_ABORT_OVR]   = abort_ovr_q;
                    rdata_d[hvcr_pkg::POS_IRQ_OVR]     = irq_ovr_q;
                    rdata_d[hvcr_pkg::POS_FIQ_OVR]     = fiq_ovr_q;
                    rdata_d[hvcr_pkg::POS_SETWAY_OVR]  = setway_read;
                    rdata_d[hvcr_pkg::POS_VIRT_EN]     = virt_en_q;
                end
                hvcr_pkg::SEL_SECOND: begin
                    rdata_d[hvcr_pkg::POS_MISMATCH_COH] = mismatch_read;
                end
                hvcr_pkg::SEL_DEBUG: rdata_d = debug_ctrl_q;
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Access answer one cycle after the request; refused reads return zero
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SYS_ACK_O   <= 1'b0;
            SYS_HIT_O   <= 1'b0;
            SYS_RDATA_O <= 32'h0000_0000;
            SYS_TRAP_O  <= 1'b0;
            SYS_UNDEF_O <= 1'b0;
        end else begin
            SYS_ACK_O   <= SYS_REQ_I;
            SYS_HIT_O   <= SYS_REQ_I && (sel != hvcr_pkg::SEL_NONE);
            SYS_RDATA_O <= SYS_REQ_I ? rdata_d : 32'h0000_0000;
            SYS_TRAP_O  <= SYS_REQ_I && trap;
            SYS_UNDEF_O <= SYS_REQ_I && undef;
        end
    end

    // Virtual exceptions as levels, same form as the physical lines so the guest sees no difference
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            VIRT_ABORT_O <= 1'b0;
            VIRT_IRQ_O   <= 1'b0;
            VIRT_FIQ_O   <= 1'b0;
        end else begin
            VIRT_ABORT_O <= vabort_pend_q && abort_ovr_eff;
            VIRT_IRQ_O   <= virq_pend_q && irq_ovr_eff;
            VIRT_FIQ_O   <= vfiq_pend_q && fiq_ovr_eff;
        end
    end

    // An active override hides the status mask from physical routing
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ABORT_MASK_EFF_O <= 1'b0;
            IRQ_MASK_EFF_O   <= 1'b0;
            FIQ_MASK_EFF_O   <= 1'b0;
        end else begin
            ABORT_MASK_EFF_O <= STATUS_ABORT_MASK_I && !abort_ovr_eff;
            IRQ_MASK_EFF_O   <= STATUS_IRQ_MASK_I && !irq_ovr_eff;
            FIQ_MASK_EFF_O   <= STATUS_FIQ_MASK_I && !fiq_ovr_eff;
        end
    end

    // Memory-system controls; stage 2 applies only below hypervisor level
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            STAGE2_EN_O    <= 1'b0;
            MISMATCH_COH_O <= 1'b0;
        end else begin
            STAGE2_EN_O    <= virt_en_eff && (CUR_LEVEL_I != hvcr_pkg::LVL_HYP);
            MISMATCH_COH_O <= mismatch_read && (CUR_LEVEL_I != hvcr_pkg::LVL_HYP);
        end
    end

    // Maintenance rewriting
    hvcr_cmo_xlate u_cmo (
        .op_i          (CMO_OP_I),
        .level_i       (CUR_LEVEL_I),
        .force_bcast_i (force_bcast_q),
        .setway_ovr_i  (setway_ovr_eff),
        .virt_en_i     (virt_en_eff),
        .op_o          (cmo_op_d),
        .bcast_o       (cmo_bcast_d)
    );

    // Registered so the cache side sees a clean one-cycle-late request
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            CMO_REQ_O   <= 1'b0;
            CMO_OP_O    <= hvcr_pkg::CMO_OTHER;
            CMO_BCAST_O <= 1'b0;
        end else begin
            CMO_REQ_O   <= CMO_REQ_I;
            CMO_OP_O    <= CMO_REQ_I ? cmo_op_d : hvcr_pkg::CMO_OTHER;
            CMO_BCAST_O <= CMO_REQ_I && cmo_bcast_d;
        end
    end

endmodule

// *** tb/hvcr_properties.sv ***
// Port checker for the hypervisor configuration bank.
// Assumes binding to hvcr_regs; sees only its ports.
`timescale 1ns/10ps
module hvcr_properties (
    input wire logic CLK_I, RESET_N_I, SYS_REQ_I, SYS_ACK_O, SYS_HIT_O, SYS_TRAP_O, SYS_UNDEF_O, // Access
    input wire logic HYP_TRAP_T1_I, TRAP_GEN_EXC_I, DEFAULT_CACHE_I, CMO_REQ_I, CMO_REQ_O, STAGE2_EN_O, // Controls
    input wire logic VIRT_IRQ_O, IRQ_MASK_EFF_O, ABORT_MASK_EFF_O, FIQ_MASK_EFF_O, // Exception levels
    input wire logic [31:0] SYS_RDATA_O, // Read data
    input wire hvcr_pkg::hvcr_level_t CUR_LEVEL_I, // Level
    input wire hvcr_pkg::hvcr_cmo_t CMO_OP_I, CMO_OP_O // Maintenance ops
);
    logic live_q;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_taken; SYS_REQ_I; endsequence
    sequence s_answer; SYS_ACK_O; endsequence
    // Past-value checks skip the first edge, whose past lies inside reset
    always_ff @(posedge CLK_I or negedge RESET_N_I) live_q <= RESET_N_I;
    a_ack_late: assert property (s_taken |=> s_answer)
        else $error("access not answered");
    a_ack_quiet: assert property (!SYS_REQ_I |=> !SYS_ACK_O && SYS_RDATA_O == 32'h0)
        else $error("stray answer");
    a_user_undef: assert property (s_taken ##0 CUR_LEVEL_I == hvcr_pkg::LVL_USER |=> SYS_UNDEF_O == SYS_HIT_O)
        else $error("user access not refused");
    a_guest_trap: assert property (s_taken ##0 CUR_LEVEL_I == hvcr_pkg::LVL_GUEST && HYP_TRAP_T1_I |=> SYS_TRAP_O == SYS_HIT_O)
        else $error("guest access not trapped");
    a_virt_excl: assert property (!(VIRT_IRQ_O && IRQ_MASK_EFF_O))
        else $error("virtual irq and mask both on");
    a_tge_unmask: assert property (live_q && $past(TRAP_GEN_EXC_I) |-> !(ABORT_MASK_EFF_O | IRQ_MASK_EFF_O | FIQ_MASK_EFF_O))
        else $error("mask kept under trap control");
    a_dc_stage2: assert property (live_q && $past(DEFAULT_CACHE_I) && $past(CUR_LEVEL_I) == hvcr_pkg::LVL_GUEST |-> STAGE2_EN_O)
        else $error("stage2 off under default cacheability");
    a_vm_clean: assert property (CMO_REQ_I && DEFAULT_CACHE_I && CUR_LEVEL_I == hvcr_pkg::LVL_GUEST && CMO_OP_I == hvcr_pkg::CMO_DC_INVAL_SETWAY |=> CMO_REQ_O && CMO_OP_O == hvcr_pkg::CMO_DC_CLEAN_INV_SW)
        else $error("set/way invalidate not upgraded");
endmodule
bind hvcr_regs hvcr_properties chk_u (.CLK_I, .RESET_N_I, .SYS_REQ_I, .SYS_ACK_O, .SYS_HIT_O, .SYS_TRAP_O, .SYS_UNDEF_O,
    .HYP_TRAP_T1_I, .TRAP_GEN_EXC_I, .DEFAULT_CACHE_I, .CMO_REQ_I, .CMO_REQ_O, .STAGE2_EN_O, .VIRT_IRQ_O,
    .IRQ_MASK_EFF_O, .ABORT_MASK_EFF_O, .FIQ_MASK_EFF_O, .SYS_RDATA_O, .CUR_LEVEL_I, .CMO_OP_I, .CMO_OP_O);

// *** tb/hvcr_core_model.sv ***
// Core-side model issuing maintenance operations.
// Assumes fire_i changes just after a clock edge.
`timescale 1ns/10ps
module hvcr_core_model (
    input  wire logic                clk_i,  // Core clock
    input  wire logic                fire_i, // Issue one operation
    input  wire hvcr_pkg::hvcr_cmo_t op_i,   // Operation to issue
    output logic                     req_o,  // Valid pulse
    output hvcr_pkg::hvcr_cmo_t      op_o    // Idle code between ops
);
    // Idle code between ops so a stale op never looks valid
    always_ff @(posedge clk_i) begin
        req_o <= fire_i;
        op_o  <= fire_i ? op_i : hvcr_pkg::CMO_OTHER;
    end
endmodule

// *** tb/hvcr_regs_tb.sv ***
// Self-checking bench for the hypervisor configuration bank.
// Assumes the package, design and core model are compiled first.
`timescale 1ns/10ps
module hvcr_regs_tb;
    localparam hvcr_pkg::hvcr_level_t HYP = hvcr_pkg::LVL_HYP;
    localparam hvcr_pkg::hvcr_level_t GST = hvcr_pkg::LVL_GUEST;
    logic clk, rst_n, req, wr, t1, trap_general_exceptions, dc, fire, bad;
    logic [2:0] opc2, st;
    logic [31:0] wd, cfg_m, sec_m, dbg_m, r;
    hvcr_pkg::hvcr_level_t lvl;
    hvcr_pkg::hvcr_cmo_t cop, cmo_op, op_out;
    wire logic ack, hit, trap, undef, cmo_req, creq, cbc, s2, mc;
    wire logic [2:0] virt, meff;
    wire logic [31:0] rd;
    int fail_count, checks_done, cyc, seed, i;
    hvcr_core_model core_u (.clk_i(clk), .fire_i(fire), .op_i(cop), .req_o(cmo_req), .op_o(cmo_op));
    hvcr_regs dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .SYS_REQ_I(req), .SYS_WRITE_I(wr),
        .SYS_COPROC_I(hvcr_pkg::ENC_COPROC), .SYS_OPC1_I(hvcr_pkg::ENC_OPC1), .SYS_CRN_I(hvcr_pkg::ENC_CRN),
        .SYS_CRM_I(hvcr_pkg::ENC_CRM ^ {bad, 3'h0}), .SYS_OPC2_I(opc2), .SYS_WDATA_I(wd), .CUR_LEVEL_I(lvl),
        .HYP_TRAP_T1_I(t1),
        .TRAP_GEN_EXC_I(trap_general_exceptions), .DEFAULT_CACHE_I(dc), .STATUS_ABORT_MASK_I(st[2]), .STATUS_IRQ_MASK_I(st[1]),
        .STATUS_FIQ_MASK_I(st[0]), .CMO_REQ_I(cmo_req), .CMO_OP_I(cmo_op), .SYS_ACK_O(ack), .SYS_HIT_O(hit),
        .SYS_RDATA_O(rd), .SYS_TRAP_O(trap), .SYS_UNDEF_O(undef), .VIRT_ABORT_O(virt[2]), .VIRT_IRQ_O(virt[1]),
        .VIRT_FIQ_O(virt[0]), .ABORT_MASK_EFF_O(meff[2]), .IRQ_MASK_EFF_O(meff[1]), .FIQ_MASK_EFF_O(meff[0]),
        .STAGE2_EN_O(s2), .MISMATCH_COH_O(mc), .CMO_REQ_O(creq), .CMO_OP_O(op_out), .CMO_BCAST_O(cbc));
    // Reads of unmapped or reserved places must come back zero
    function automatic logic [31:0] exp_rd(input logic [2:0] o);
        return o == 3'h0 ? cfg_m & 32'h3FB : o == 3'h4 ? sec_m & 32'h40 : o == 3'h1 ? dbg_m : 32'h0;
    endfunction
    function automatic logic [3:0] exp_cmo(input hvcr_pkg::hvcr_cmo_t o);
        logic g;
        g = lvl == GST;
        if (g && o == hvcr_pkg::CMO_DC_INVAL_SETWAY && (cfg_m[1] | cfg_m[0] | dc)) o = hvcr_pkg::CMO_DC_CLEAN_INV_SW;
        if (g && o == hvcr_pkg::CMO_DC_INVAL_ADDR && (cfg_m[0] | dc)) o = hvcr_pkg::CMO_DC_CLEAN_INV_ADDR;
        return {g && cfg_m[9] && o <= hvcr_pkg::CMO_IC_INVAL_ALL, o};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One access, then one maintenance op with fresh masks and controls
    task automatic step(input logic w, input logic [2:0] o, input hvcr_pkg::hvcr_level_t l, input logic t,
                        input logic [31:0] d);
        logic h;
        logic [2:0] ov;
        h = (w || !d[31]) && (o == 3'h0 || o == 3'h1 || o == 3'h4);
        @(posedge clk);
        req <= 1'b1; wr <= w; opc2 <= o; lvl <= l; t1 <= t; wd <= d; bad <= !w && d[31];
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
        chk({ack, hit, trap, undef}, {1'b1, h, h && l == GST && t, h && l != HYP && !(l == GST && t)});
        chk(rd, !w && l == HYP && h ? exp_rd(o) : 32'h0);
        if (w && l == HYP && o == 3'h0) cfg_m = d;
        if (w && l == HYP && o == 3'h4) sec_m = d;
        if (w && l == HYP && o == 3'h1) dbg_m = d;
        r = $random(seed);
        @(posedge clk);
        st <= r[2:0]; trap_general_exceptions <= r[3]; dc <= r[4]; fire <= 1'b1; cop <= hvcr_pkg::hvcr_cmo_t'(r[7:5] % 3'h7);
        @(posedge clk);
        fire <= 1'b0;
        @(negedge clk);
        ov = cfg_m[5:3] | {3{trap_general_exceptions}};
        chk(virt, cfg_m[8:6] & ov);
        chk(meff, st & ~ov);
        chk({s2, mc}, {(cfg_m[0] | dc) & (lvl != HYP), sec_m[6] & (lvl != HYP)});
        @(negedge clk);
        chk({creq, cbc, op_out}, {1'b1, exp_cmo(cop)});
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // A hung handshake counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    // Reset reads, refused and unmapped corners, then random traffic
    initial begin
        {rst_n, req, wr, t1, trap_general_exceptions, dc, fire, bad, opc2, st, wd, cfg_m, sec_m, dbg_m} = '0;
        lvl = HYP;
        cop = hvcr_pkg::CMO_OTHER;
        seed = 60;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 3; i++) step(1'b0, i == 2 ? 3'h4 : 3'(i), HYP, 1'b0, 32'h0);
        step(1'b1, 3'h0, HYP, 1'b0, 32'hFFFF_FFFF);
        step(1'b1, 3'h0, GST, 1'b1, 32'h0);
        step(1'b1, 3'h4, hvcr_pkg::LVL_USER, 1'b0, 32'hFFFF_FFFF);
        step(1'b0, 3'h2, HYP, 1'b0, 32'h0);
        for (i = 0; i < 400; i++) begin
            r = $random(seed);
            step(r[0], r[3] ? {r[2], 2'b00} : r[2:0], r[5] ? HYP : hvcr_pkg::hvcr_level_t'(r[9:8]), r[7], $random(seed));
        end
        wrap_up();
    end
endmodule
